// >>> logic/cmrr_pkg.sv
// Purpose: constants for the memory-port read-modify-write/refresh sequencer
// Assumes: 100 MHz clock, four equal phases per machine cycle
// Notes: bus bit 0 is the msb-numbered line, mapped to index 0 here
package cmrr_pkg;
  // phase timing
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned PHASE_NS = 120;
  localparam int unsigned PHASE_CYC = (PHASE_NS + CLK_PERIOD_NS - 1)
                                      / CLK_PERIOD_NS;
  localparam logic [3:0] PHASE_CNT_LAST = 4'(PHASE_CYC - 1);
  // phase encoding (phase 1..4 held as 0..3)
  localparam logic [1:0] PH1 = 2'h0;
  localparam logic [1:0] PH2 = 2'h1;
  localparam logic [1:0] PH3 = 2'h2;
  localparam logic [1:0] PH4 = 2'h3;
  // refresh address pattern: bits 0..9 ones
  localparam logic [9:0] REFRESH_FILL = 10'h3ff;
  localparam int unsigned REFRESH_ROW_W = 6;
  // sequencer states
  typedef enum logic [3:0] {
    CMRR_IDLE = 4'h0,
    CMRR_ADDR = 4'h1,
    CMRR_RMW_RD = 4'h2,
    CMRR_RMW_WAIT = 4'h3,
    CMRR_RMW_WR = 4'h4,
    CMRR_RMW_DATA = 4'h5,
    CMRR_RMW_END = 4'h6,
    CMRR_REF_RUN = 4'h7,
    CMRR_REF_END = 4'h8
  } cmrr_state_t;
endpackage : cmrr_pkg

// >>> logic/cmrr_seq.sv
// Purpose: memory-port sequencer for read-modify-write and refresh
// Assumes: bus is open-drain with external pull/precharge resolution
`timescale 1ns/100ps
module cmrr_seq (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // operation request
  input wire logic req_valid_i,
  input wire logic req_refresh_i,
  input wire logic [14:0] req_addr_i,
  input wire logic [5:0] req_row_i,
  output logic req_ready_o,
  // modify handshake
  output logic rd_valid_o,
  output logic [15:0] rd_data_o,
  input wire logic wr_valid_i,
  input wire logic [15:0] wr_data_i,
  // memory port
  output logic memory_strobe_o,
  output logic read_enable_strobe_o,
  output logic write_enable_strobe_o,
  output logic [15:0] bus_o,
  output logic [15:0] bus_oe_o,
  output logic bus_precharge_o,
  input wire logic [15:0] bus_i,
  // phase indicator
  output logic [1:0] phase_o
);
  cmrr_pkg::cmrr_state_t state_q, state_d;
  logic [3:0] cnt_q, cnt_d;
  logic [1:0] ph_q, ph_d;
  logic [15:0] bus_s1_q, bus_s2_q;
  logic refresh_q, refresh_d;
  logic [15:0] addr_q, addr_d;
  logic [15:0] dat_q, dat_d;
  logic [15:0] rdat_q, rdat_d;
  logic rdv_q, rdv_d;
  logic pg_q, pg_d, re_q, re_d, we_q, we_d;
  logic [15:0] drv_q, drv_d;
  logic oe_q, oe_d;
  logic ph_end;
  logic [1:0] ph_next;

  // phase counter: 12 clocks per phase
  assign ph_end = (cnt_q == cmrr_pkg::PHASE_CNT_LAST);
  assign ph_next = ph_q + 2'h1;

  // pin synchroniser for the bus
  // the word is read only at the end of a 12-clock phase, so the two
  // flops of delay cost nothing and no line is caught mid-transition
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bus_s1_q <= 16'hffff;
      bus_s2_q <= 16'hffff;
    end else begin
      bus_s1_q <= bus_i;
      bus_s2_q <= bus_s1_q;
    end
  end

  // next state; the datum latch acts on any clock, the rest at phase
  // boundaries, where the case decisions name the phase being entered
  always_comb begin
    state_d = state_q;
    cnt_d = ph_end ? 4'h0 : cnt_q + 4'h1;
    ph_d = ph_end ? ph_next : ph_q;
    refresh_d = refresh_q;
    addr_d = addr_q;
    dat_d = dat_q;
    rdat_d = rdat_q;
    rdv_d = 1'b0;
    pg_d = pg_q;
    re_d = re_q;
    we_d = we_q;
    drv_d = drv_q;
    oe_d = oe_q;
    // sample at the last clock of phase 3 after read precharge
    // bus_s2_q lags two clocks, still inside the settled window
    if (ph_end && ph_q == cmrr_pkg::PH3 &&
        state_q == cmrr_pkg::CMRR_RMW_RD) begin
      rdat_d = bus_s2_q;
      rdv_d = 1'b1;
      state_d = cmrr_pkg::CMRR_RMW_WAIT;
    end
    // latch modified datum once offered
    // a late offer simply pushes the write into a later phase 3
    if (state_q == cmrr_pkg::CMRR_RMW_WAIT && wr_valid_i) begin
      dat_d = wr_data_i;
      state_d = cmrr_pkg::CMRR_RMW_WR;
    end
    if (ph_end) begin
      oe_d = 1'b0; // neutral unless driven below
      case (ph_next)
        cmrr_pkg::PH4: begin
          re_d = 1'b0;
          if (we_q && !refresh_q) begin
            we_d = 1'b0;
            drv_d = dat_q;
            oe_d = 1'b1;
            state_d = cmrr_pkg::CMRR_RMW_END;
          end else if (state_q == cmrr_pkg::CMRR_IDLE && req_valid_i) begin
            refresh_d = req_refresh_i;
            // index i carries bus bit i: refresh fill sits in the low
            // ten lines, an address shifts up one so bit 0 stays low
            addr_d = req_refresh_i ?
              {req_row_i, cmrr_pkg::REFRESH_FILL} :
              {req_addr_i, 1'b0};
            drv_d = addr_d;
            oe_d = 1'b1;
            state_d = cmrr_pkg::CMRR_ADDR;
          end
        end
        cmrr_pkg::PH1: begin
          // refresh write enable spans phases 3 and 4, dropping here
          if (we_q && refresh_q)
            we_d = 1'b0;
          if (state_q == cmrr_pkg::CMRR_ADDR) begin
            pg_d = 1'b1;
            state_d = refresh_q ? cmrr_pkg::CMRR_REF_RUN :
                                  cmrr_pkg::CMRR_RMW_RD;
            cnt_d = 4'h0;
          end
        end
        cmrr_pkg::PH2: begin
          if (state_q == cmrr_pkg::CMRR_RMW_RD && pg_q && !re_q)
            re_d = 1'b1;
        end
        default: begin // entering phase 3
          case (state_q)
            cmrr_pkg::CMRR_REF_RUN: begin
              we_d = 1'b1;
              state_d = cmrr_pkg::CMRR_REF_END;
            end
            cmrr_pkg::CMRR_REF_END: begin
              pg_d = 1'b0;
              state_d = cmrr_pkg::CMRR_IDLE;
            end
            cmrr_pkg::CMRR_RMW_WR:
              we_d = 1'b1;
            cmrr_pkg::CMRR_RMW_END: begin
              pg_d = 1'b0;
              state_d = cmrr_pkg::CMRR_IDLE;
            end
            default: ;
          endcase
        end
      endcase
    end
  end

  // register the sequencer
  // every register steps on every edge; decisions live in the comb block
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= cmrr_pkg::CMRR_IDLE;
      cnt_q <= 4'h0;
      ph_q <= cmrr_pkg::PH1;
      refresh_q <= 1'b0;
      addr_q <= 16'h0000;
      dat_q <= 16'h0000;
      rdat_q <= 16'h0000;
      rdv_q <= 1'b0;
      pg_q <= 1'b0;
      re_q <= 1'b0;
      we_q <= 1'b0;
      drv_q <= 16'h0000;
      oe_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      ph_q <= ph_d;
      refresh_q <= refresh_d;
      addr_q <= addr_d;
      dat_q <= dat_d;
      rdat_q <= rdat_d;
      rdv_q <= rdv_d;
      pg_q <= pg_d;
      re_q <= re_d;
      we_q <= we_d;
      drv_q <= drv_d;
      oe_q <= oe_d;
    end
  end

  // open drain: only zero bits are pulled, ones stay undriven
  // precharge is decoded from the phase alone, so it holds while idle;
  // anything outside pulling a line low in phase 2 risks damage
  assign bus_o = 16'h0000;
  assign bus_oe_o = oe_q ? ~drv_q : 16'h0000;
  assign bus_precharge_o = (ph_q == cmrr_pkg::PH2);
  assign memory_strobe_o = pg_q;
  assign read_enable_strobe_o = re_q & ~refresh_q;
  assign write_enable_strobe_o = we_q;
  assign rd_valid_o = rdv_q;
  assign rd_data_o = rdat_q;
  assign req_ready_o = (state_q == cmrr_pkg::CMRR_IDLE);
  assign phase_o = ph_q;
endmodule : cmrr_seq

// >>> verif/cmrr_seq_props.sv
// Purpose: port checks of the memory-port sequencer
// Assumes: phase_o steps 0..3 once per phase
// Notes: single clock domain
`timescale 1ns/100ps
module cmrr_seq_props (
  // watched ports
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic memory_strobe_o,
  input wire logic read_enable_strobe_o,
  input wire logic write_enable_strobe_o,
  input wire logic [15:0] bus_oe_o,
  input wire logic bus_precharge_o,
  input wire logic [1:0] phase_o
);
  logic [3:0] cnt_q;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // cycles since phase step; f until the first step is seen
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) cnt_q <= 4'hf;
    else if ($changed(phase_o)) cnt_q <= 4'h0;
    else if (cnt_q != 4'hf) cnt_q <= cnt_q + 4'h1;
  end
  phase_step_a: assert property ($changed(phase_o) |->
    phase_o == $past(phase_o) + 2'h1) else $error("phase out of order");
  phase_len_a: assert property ($changed(phase_o) && cnt_q != 4'hf
    |-> cnt_q == 4'hb) else $error("phase not 12 clocks");
  strobe_rise_a: assert property ($rose(memory_strobe_o) |->
    phase_o == 2'h0 && bus_oe_o == 16'h0000) else $error("strobe rise");
  strobe_fall_a: assert property ($fell(memory_strobe_o) |->
    phase_o == 2'h2 && !write_enable_strobe_o) else $error("strobe fall");
  rd_rise_a: assert property ($rose(read_enable_strobe_o) |->
    phase_o == 2'h1 && $past(memory_strobe_o, 12)) else $error("rd rise");
  rd_fall_a: assert property ($fell(read_enable_strobe_o) |->
    phase_o == 2'h3 && $past(read_enable_strobe_o, 24)) else $error("rd");
  we_rise_a: assert property ($rose(write_enable_strobe_o) |->
    phase_o == 2'h2 && memory_strobe_o) else $error("we rise");
  we_fall_a: assert property ($fell(write_enable_strobe_o) |->
    phase_o != 2'h2 && $past(write_enable_strobe_o, 12)) else $error("we");
  precharge_a: assert property (phase_o == 2'h1 |->
    bus_precharge_o && bus_oe_o == 16'h0000) else $error("no precharge");
endmodule : cmrr_seq_props
bind cmrr_seq cmrr_seq_props u_props (.clk_i, .rst_n_i, .memory_strobe_o,
  .read_enable_strobe_o, .write_enable_strobe_o, .bus_oe_o,
  .bus_precharge_o, .phase_o);

// >>> verif/cmrr_mem_model.sv
// Purpose: dynamic memory behind the shared bus
// Assumes: lines keep their charge while undriven
// Notes: eight words, low address bits select
`timescale 1ns/100ps
module cmrr_mem_model (
  // memory port
  input wire logic clk_i,
  input wire logic strobe_i,
  input wire logic rd_en_i,
  input wire logic wr_en_i,
  input wire logic precharge_i,
  input wire logic [15:0] oe_i,
  input wire logic [1:0] phase_i,
  // resolved bus level
  output logic [15:0] bus_o
);
  logic [15:0] mem [8] = '{default: 16'h0000};
  logic [15:0] held_q = 16'hffff;
  logic [2:0] idx_q = 3'h0;
  logic strobe_q = 1'b0;
  logic rmw_q = 1'b0;
  logic wr_q = 1'b0;
  logic [15:0] pull;
  // zeros pulled only in the sampling phase 3
  assign pull = rd_en_i && phase_i == 2'h2 ? ~mem[idx_q] : 16'h0000;
  assign bus_o = precharge_i ? 16'hffff : held_q & ~(oe_i | pull);
  // address latched as strobe rises, datum taken in write phase 4
  always @(posedge clk_i) begin
    held_q <= bus_o;
    strobe_q <= strobe_i;
    if (strobe_i && !strobe_q) idx_q <= bus_o[3:1];
    if (rd_en_i) rmw_q <= 1'b1;
    if (wr_en_i && rmw_q) wr_q <= 1'b1;
    if (wr_q && !wr_en_i) begin
      mem[idx_q] <= bus_o;
      wr_q <= 1'b0;
      rmw_q <= 1'b0;
    end
  end
endmodule : cmrr_mem_model

// >>> verif/cmrr_seq_tb.sv
// Purpose: random rmw and refresh traffic against a memory model
// Assumes: reads return what the previous rmw wrote
// Notes: read data compared through a queue
`timescale 1ns/100ps
module cmrr_seq_tb;
  logic clk_i = 1'b0, rst_n_i = 1'b0, req_valid_i = 1'b0, wr_valid_i = 1'b0;
  logic req_refresh_i = 1'b0, req_ready_o, rd_valid_o, bus_precharge_o;
  logic memory_strobe_o, read_enable_strobe_o, write_enable_strobe_o;
  logic [14:0] req_addr_i = 15'h0000;
  logic [5:0] req_row_i = 6'h00;
  logic [15:0] wr_data_i = 16'h0000, rd_data_o, bus_o, bus_oe_o, bus_i;
  logic [1:0] phase_o;
  logic strobe_seen = 1'b0;
  logic [15:0] exp_addr;
  logic [15:0] img [8] = '{default: 16'h0000};
  logic [15:0] exp_q [$];
  int err_total = 0;
  int n_compared = 0;
  always #5 clk_i = ~clk_i;
  cmrr_seq DUT (.clk_i, .rst_n_i, .req_valid_i, .req_refresh_i, .req_addr_i,
    .req_row_i, .req_ready_o, .rd_valid_o, .rd_data_o, .wr_valid_i,
    .wr_data_i, .memory_strobe_o, .read_enable_strobe_o,
    .write_enable_strobe_o, .bus_o, .bus_oe_o, .bus_precharge_o, .bus_i,
    .phase_o);
  cmrr_mem_model u_mem (.clk_i(clk_i), .strobe_i(memory_strobe_o),
    .rd_en_i(read_enable_strobe_o), .wr_en_i(write_enable_strobe_o),
    .precharge_i(bus_precharge_o), .oe_i(bus_oe_o), .phase_i(phase_o),
    .bus_o(bus_i));
  task automatic check(input string what, input logic [15:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic print_verdict();
    if (err_total == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict
  // bounded wait on the idle flag, a hang ends the run
  task automatic wait_ready(input logic lvl, input int lim);
    while (req_ready_o !== lvl) begin
      @(posedge clk_i);
      #1;
      lim--;
      if (lim < 0) begin
        err_total++;
        print_verdict();
      end
    end
  endtask : wait_ready
  // address the bus must still carry as the strobe is first seen high
  assign exp_addr = req_refresh_i ? {req_row_i, cmrr_pkg::REFRESH_FILL}
                                  : {req_addr_i, 1'b0};
  // each read pulse takes the oldest note
  always @(posedge clk_i) begin
    strobe_seen <= memory_strobe_o;
    if (memory_strobe_o === 1'b1 && strobe_seen === 1'b0)
      check("strobe address", bus_i, exp_addr);
    if (rd_valid_o === 1'b1 && exp_q.size() == 0)
      check("read pulse", 16'h0001, 16'h0000);
    else if (rd_valid_o === 1'b1)
      check("read datum", rd_data_o, exp_q.pop_front());
  end
  // random back-to-back operations, write offered after a random delay
  initial begin
    void'($urandom(27843));
    repeat (10) @(posedge clk_i);
    #1;
    rst_n_i = 1'b1;
    for (int k = 0; k < 40; k++) begin
      req_refresh_i = ($urandom % 3) == 0;
      req_addr_i = 15'($urandom);
      req_row_i = 6'($urandom);
      wr_data_i = 16'($urandom);
      if (!req_refresh_i) exp_q.push_back(img[req_addr_i[2:0]]);
      if (!req_refresh_i) img[req_addr_i[2:0]] = wr_data_i;
      req_valid_i = 1'b1;
      wait_ready(1'b0, 60);
      req_valid_i = 1'b0;
      repeat ($urandom % 60 + 1) @(posedge clk_i);
      #1;
      wr_valid_i = !req_refresh_i;
      wait_ready(1'b1, 400);
      wr_valid_i = 1'b0;
    end
    repeat (60) @(posedge clk_i);
    check("notes left", 16'(exp_q.size()), 16'h0000);
    print_verdict();
  end
endmodule : cmrr_seq_tb
